//--- rtl/srbc_pkg.sv
// constants and types for the burst address and sleep control block
package srbc_pkg;

  localparam int ADDR_W  = 19;
  localparam int DATA_W  = 36;
  localparam int BYTE_W  = 9;
  localparam int NBYTES  = 4;
  localparam int REG_AW  = 8;
  localparam int REG_DW  = 32;
  localparam int CNT_W   = 16;

  localparam int CLK_PERIOD_NS        = 5;
  localparam int SLEEP_ENTRY_CYC      = 2;
  localparam int SLEEP_RECOVERY_TIME_NS = 100;
  localparam int SLEEP_RECOVERY_CYC   =
    (SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [REG_AW-1:0] REG_RECOVERY_OFS = 8'h00;
  localparam logic [REG_AW-1:0] REG_STATUS_OFS   = 8'h04;
  localparam logic [CNT_W-1:0]  RECOVERY_RST     = CNT_W'(SLEEP_RECOVERY_CYC);

  localparam int ST_SREQ_BIT  = 0;
  localparam int ST_SLP_LSB   = 1;
  localparam int ST_IO_LSB    = 3;
  localparam int ST_BEAT_LSB  = 5;
  localparam int ST_ORDER_BIT = 7;

  typedef enum logic [1:0] {CMD_WRITE, CMD_READ, CMD_BURST, CMD_DESEL} srbc_cmd_t;
  typedef enum logic [1:0] {IO_DESEL, IO_READ, IO_WRITE} srbc_io_t;
  typedef enum logic [1:0] {SLP_AWAKE, SLP_ENTER, SLP_ASLEEP, SLP_RECOVER} srbc_slp_t;

endpackage

//--- rtl/srbc_core.sv
// burst address generation, late-write data path and sleep control of a flow-through ram
`timescale 1ns/1ps
`default_nettype none

module srbc_core
  import srbc_pkg::*;
(
  input  wire logic                        i_core_clk,             // core clock, 200 MHz
  input  wire logic                        i_rst_n,                // async reset, active low
  input  wire logic                        i_clk_enable_n,         // clock enable, active low
  input  wire logic                        i_burst_step_enable,    // advance burst counter
  input  wire logic [srbc_pkg::ADDR_W-1:0] i_addr,                 // word address
  input  wire logic                        i_write_n,              // write enable, active low
  input  wire logic [srbc_pkg::NBYTES-1:0] i_byte_write_n,         // byte write strobes, active low
  input  wire logic                        i_chip_en1_n,           // chip enable, active low
  input  wire logic                        i_chip_en2,             // chip enable, active high
  input  wire logic                        i_chip_en3_n,           // chip enable, active low
  input  wire logic                        i_out_en_n,             // async output enable, active low
  input  wire logic                        i_sleep_request,        // async sleep request
  input  wire logic                        i_burst_order_select_n, // strap: low linear, high interleaved
  input  wire logic [srbc_pkg::DATA_W-1:0] i_dq,                   // data pins, input side
  output var  logic [srbc_pkg::DATA_W-1:0] o_dq,                   // data pins, output side
  output var  logic                        o_dq_oe,                // data pins driven
  output var  logic                        o_sleep_active,         // device is asleep
  input  wire logic [srbc_pkg::REG_AW-1:0] i_reg_addr,             // register address
  input  wire logic [srbc_pkg::REG_DW-1:0] i_reg_wdata,            // register write data
  input  wire logic                        i_reg_wr,               // register write strobe
  input  wire logic                        i_reg_rd,               // register read strobe
  output var  logic [srbc_pkg::REG_DW-1:0] o_reg_rdata             // read data, cycle after strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [1:0] burst_low(input logic order_n, input logic [1:0] base,
                                           input logic [1:0] beat);
    burst_low = order_n ? (base ^ beat) : 2'(base + beat);
  endfunction

  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_d,
                                                    input logic [DATA_W-1:0] new_d,
                                                    input logic [NBYTES-1:0] be);
    logic [DATA_W-1:0] res;
    res = old_d;
    for (int b = 0; b < NBYTES; b++)
      if (be[b])
        res[b*BYTE_W +: BYTE_W] = new_d[b*BYTE_W +: BYTE_W];
    merge_bytes = res;
  endfunction

  function automatic srbc_cmd_t classify(input logic step, input logic sel,
                                         input logic wr_n, input logic [NBYTES-1:0] bw_n);
    if (step)
      classify = CMD_BURST;
    else if (!sel)
      classify = CMD_DESEL;
    else if (!wr_n)
      classify = (&bw_n) ? CMD_DESEL : CMD_WRITE;
    else
      classify = CMD_READ;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  logic              sreq_s1_r, sreq_s2_r, sreq_s3_r, sreq_level_r;
  logic              g_s1_r, g_s2_r, g_s3_r, g_level_r;
  srbc_slp_t         slp_r, slp_nxt;
  logic [CNT_W-1:0]  slp_cnt_r, slp_cnt_nxt;
  logic [CNT_W-1:0]  recovery_r;
  srbc_io_t          io_r, io_nxt;
  logic [1:0]        base_r, base_nxt;
  logic [1:0]        beat_r, beat_nxt;
  logic [ADDR_W-3:0] upper_r, upper_nxt;
  logic              pend_valid_r;
  logic [ADDR_W-1:0] pend_addr_r;
  logic [NBYTES-1:0] pend_be_r;
  logic              drive_r;
  srbc_cmd_t         cmd;
  logic              awake;
  logic              run;
  logic              acc_valid;
  logic              acc_wr;
  logic [ADDR_W-1:0] acc_addr;
  logic [NBYTES-1:0] acc_be;
  logic [DATA_W-1:0] rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // asynchronous inputs: three stages, a change counts when stages two and three agree
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sreq_s1_r    <= 1'b0;
      sreq_s2_r    <= 1'b0;
      sreq_s3_r    <= 1'b0;
      sreq_level_r <= 1'b0;
      g_s1_r       <= 1'b1;
      g_s2_r       <= 1'b1;
      g_s3_r       <= 1'b1;
      g_level_r    <= 1'b1;
    end
    else
    begin
      sreq_s1_r <= i_sleep_request;
      sreq_s2_r <= sreq_s1_r;
      sreq_s3_r <= sreq_s2_r;
      g_s1_r    <= i_out_en_n;
      g_s2_r    <= g_s1_r;
      g_s3_r    <= g_s2_r;
      if (sreq_s2_r == sreq_s3_r)
        sreq_level_r <= sreq_s3_r;
      if (g_s2_r == g_s3_r)
        g_level_r <= g_s3_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep sequencing; runs regardless of the clock-enable pin
  // in entry the count starts at one: it counts edges since the synchronised request rose
  always_comb
  begin
    slp_nxt     = slp_r;
    slp_cnt_nxt = slp_cnt_r;
    unique case (slp_r)
      SLP_AWAKE:
      begin
        if (sreq_level_r)
        begin
          slp_nxt     = SLP_ENTER;
          slp_cnt_nxt = CNT_W'(1);
        end
      end
      SLP_ENTER:
      begin
        if (!sreq_level_r)
          slp_nxt = SLP_AWAKE;
        else if (slp_cnt_r == CNT_W'(SLEEP_ENTRY_CYC - 1))
          slp_nxt = SLP_ASLEEP;
        else
          slp_cnt_nxt = slp_cnt_r + 1'b1;
      end
      SLP_ASLEEP:
      begin
        if (!sreq_level_r)
        begin
          slp_nxt     = (recovery_r == '0) ? SLP_AWAKE : SLP_RECOVER;
          slp_cnt_nxt = '0;
        end
      end
      SLP_RECOVER:
      begin
        if (sreq_level_r)
        begin
          slp_nxt     = SLP_ENTER;
          slp_cnt_nxt = CNT_W'(1);
        end
        else if (slp_cnt_r >= recovery_r - 1'b1)
          slp_nxt = SLP_AWAKE;
        else
          slp_cnt_nxt = slp_cnt_r + 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      slp_r          <= SLP_AWAKE;
      slp_cnt_r      <= '0;
      o_sleep_active <= 1'b0;
    end
    else
    begin
      slp_r          <= slp_nxt;
      slp_cnt_r      <= slp_cnt_nxt;
      o_sleep_active <= (slp_nxt == SLP_ASLEEP);
    end
  end

  // pending accesses keep running through the entry window; the controller must drain first
  assign awake = (slp_r == SLP_AWAKE) || (slp_r == SLP_ENTER);
  assign run   = awake && !i_clk_enable_n;

  ////////////////////////////////////////////////////////////////////////////
  // command decode and burst address
  assign cmd = classify(i_burst_step_enable, !i_chip_en1_n && i_chip_en2 && !i_chip_en3_n,
                        i_write_n, i_byte_write_n);

  always_comb
  begin
    io_nxt    = io_r;
    base_nxt  = base_r;
    beat_nxt  = beat_r;
    upper_nxt = upper_r;
    acc_valid = 1'b0;
    acc_wr    = 1'b0;
    acc_be    = '0;
    if (run)
    begin
      unique case (cmd)
        CMD_READ, CMD_WRITE:
        begin
          io_nxt    = (cmd == CMD_WRITE) ? IO_WRITE : IO_READ;
          base_nxt  = i_addr[1:0];
          upper_nxt = i_addr[ADDR_W-1:2];
          beat_nxt  = 2'b00;
          acc_valid = 1'b1;
          acc_wr    = (cmd == CMD_WRITE);
          acc_be    = ~i_byte_write_n;
        end
        CMD_BURST:
        begin
          beat_nxt  = 2'(beat_r + 2'b01);
          acc_valid = (io_r != IO_DESEL);
          acc_wr    = (io_r == IO_WRITE);
          acc_be    = ~i_byte_write_n;
        end
        CMD_DESEL:
        begin
          io_nxt = IO_DESEL;
        end
      endcase
    end
  end

  assign acc_addr = {upper_nxt, burst_low(i_burst_order_select_n, base_nxt, beat_nxt)};

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      io_r    <= IO_DESEL;
      base_r  <= 2'b00;
      beat_r  <= 2'b00;
      upper_r <= '0;
    end
    else
    begin
      io_r    <= io_nxt;
      base_r  <= base_nxt;
      beat_r  <= beat_nxt;
      upper_r <= upper_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // late write: address and strobes now, data on the next enabled edge
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pend_valid_r <= 1'b0;
      pend_addr_r  <= '0;
      pend_be_r    <= '0;
    end
    else if (run)
    begin
      pend_valid_r <= acc_valid && acc_wr;
      pend_addr_r  <= acc_addr;
      pend_be_r    <= acc_be;
    end
  end

  // no reset on the array: contents survive reset and sleep alike
  always_ff @(posedge i_core_clk)
  begin
    if (run && pend_valid_r)
      mem[pend_addr_r] <= merge_bytes(mem[pend_addr_r], i_dq, pend_be_r);
  end

  // a read right behind a write to the same word must see the data being written
  always_comb
  begin
    rd_data = mem[acc_addr];
    if (pend_valid_r && (pend_addr_r == acc_addr))
      rd_data = merge_bytes(rd_data, i_dq, pend_be_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and output drive
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_dq    <= '0;
      drive_r <= 1'b0;
      o_dq_oe <= 1'b0;
    end
    else
    begin
      if (run && acc_valid && !acc_wr)
        o_dq <= rd_data;
      // a stalled read keeps the bus driven; a stalled write keeps it released
      if (run)
      begin
        drive_r <= acc_valid && !acc_wr;
      end
      o_dq_oe <= (slp_nxt == SLP_AWAKE || slp_nxt == SLP_ENTER) && !g_level_r &&
                 (run ? (acc_valid && !acc_wr) : drive_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      recovery_r <= RECOVERY_RST;
    else if (i_reg_wr && (i_reg_addr == REG_RECOVERY_OFS))
      recovery_r <= i_reg_wdata[CNT_W-1:0];
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_reg_rdata <= '0;
    end
    else
    begin
      o_reg_rdata <= '0;
      if (i_reg_rd && (i_reg_addr == REG_RECOVERY_OFS))
      begin
        o_reg_rdata[CNT_W-1:0] <= recovery_r;
      end
      else if (i_reg_rd && (i_reg_addr == REG_STATUS_OFS))
      begin
        o_reg_rdata[ST_SREQ_BIT]               <= sreq_level_r;
        o_reg_rdata[ST_SLP_LSB +: 2]           <= slp_r;
        o_reg_rdata[ST_IO_LSB +: 2]            <= io_r;
        o_reg_rdata[ST_BEAT_LSB +: 2]          <= beat_r;
        o_reg_rdata[ST_ORDER_BIT]              <= i_burst_order_select_n;
      end
    end
  end

endmodule

`default_nettype wire

//--- sim/srbc_core_props.sv
// assertions on the ports of the burst and sleep block
`timescale 1ns/1ps
`default_nettype none
module srbc_core_props
  import srbc_pkg::*;
(
  input wire logic                        i_core_clk,          // clock
  input wire logic                        i_rst_n,             // reset
  input wire logic                        i_clk_enable_n,      // hold
  input wire logic                        i_burst_step_enable, // step
  input wire logic                        i_write_n,           // write
  input wire logic                        i_chip_en1_n,        // enable 1
  input wire logic                        i_chip_en2,          // enable 2
  input wire logic                        i_chip_en3_n,        // enable 3
  input wire logic                        i_sleep_request,     // sleep
  input wire logic [srbc_pkg::DATA_W-1:0] o_dq,                // data out
  input wire logic                        o_dq_oe,             // pins driven
  input wire logic                        o_sleep_active       // asleep
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // eight samples leave room for the three-stage sync plus entry delay
  sequence s_slp_held;
    i_sleep_request [*8];
  endsequence
  sequence s_awake_held;
    !i_sleep_request [*8];
  endsequence
  sequence s_no_drive;
    !i_clk_enable_n && !i_burst_step_enable && !o_sleep_active &&
    (!i_write_n || i_chip_en1_n || !i_chip_en2 || i_chip_en3_n);
  endsequence
  ////////////////////////////////////////////////////////////
  chk_hold_keeps_data: assert property (i_clk_enable_n |=> $stable(o_dq))
    else $error("data changed during hold");
  chk_drive_after_read: assert property ($rose(o_dq_oe) |-> !$past(i_clk_enable_n) && !$past(o_sleep_active))
    else $error("pins driven without a taken read");
  chk_write_pins_free: assert property (s_no_drive |=> !o_dq_oe)
    else $error("pins driven after write or deselect");
  chk_sleep_entered: assert property (s_slp_held |-> o_sleep_active)
    else $error("sleep not entered");
  chk_sleep_not_early: assert property ($rose(i_sleep_request) && !o_sleep_active |=> !o_sleep_active [*2])
    else $error("sleep entered too early");
  chk_awake_normal: assert property (s_awake_held |-> !o_sleep_active)
    else $error("asleep with request low");
  chk_sleep_pins_off: assert property (o_sleep_active |-> !o_dq_oe)
    else $error("pins driven while asleep");
  chk_sleep_ignores: assert property (o_sleep_active |=> $stable(o_dq))
    else $error("data changed while asleep");
endmodule

bind srbc_core srbc_core_props u_props (
  .i_core_clk, .i_rst_n, .i_clk_enable_n, .i_burst_step_enable, .i_write_n, .i_chip_en1_n,
  .i_chip_en2, .i_chip_en3_n, .i_sleep_request, .o_dq, .o_dq_oe, .o_sleep_active
);
`default_nettype wire

//--- sim/srbc_ctl_model.sv
// controller model driving the memory pins
`timescale 1ns/1ps
`default_nettype none
module srbc_ctl_model
  import srbc_pkg::*;
(
  input  wire logic                        i_core_clk, // clock
  output var  logic                        o_cke_n,    // hold
  output var  logic                        o_step,     // burst step
  output var  logic [srbc_pkg::ADDR_W-1:0] o_addr,     // address
  output var  logic                        o_wr_n,     // write
  output var  logic [srbc_pkg::NBYTES-1:0] o_bw_n,     // byte strobes
  output var  logic                        o_sel,      // select
  output var  logic                        o_slp,      // sleep
  output var  logic                        o_ord_n,    // order strap
  output var  logic [srbc_pkg::DATA_W-1:0] o_dq        // write data
);
  initial
  begin
    {o_cke_n, o_step, o_wr_n, o_sel, o_ord_n} = 5'h04;
    o_slp = 1'b0;
    o_addr = '0;
    o_bw_n = '1;
    o_dq = '0;
  end
  task automatic mode(input logic cke_n, input logic ord_n, input logic slp);
    o_cke_n <= cke_n;
    o_ord_n <= ord_n;
    o_slp <= slp;
  endtask
  // one command cycle; dv marks the late-write word of the previous write
  task automatic cyc(input logic step, input logic wr_n, input logic [NBYTES-1:0] bw_n, input logic sel,
                     input logic [ADDR_W-1:0] a, input logic dv, input logic [DATA_W-1:0] d);
    o_step <= step;
    o_wr_n <= wr_n;
    o_bw_n <= bw_n;
    o_sel <= sel;
    o_addr <= a;
    // a released bus flips so a stale word never looks valid
    o_dq <= dv ? d : ~o_dq;
    @(posedge i_core_clk);
  endtask
endmodule
`default_nettype wire

//--- sim/srbc_core_test.sv
// self-checking bench for the burst and sleep block
`timescale 1ns/1ps
`default_nettype none
module srbc_core_test;
  import srbc_pkg::*;
  localparam logic [ADDR_W-1:0] UP = 19'h1_2340;
  logic              clk, rst_n, cke_n, step, wr_n, sel, slp, ord_n, oe, act, rwr, rrd;
  logic [ADDR_W-1:0] addr;
  logic [NBYTES-1:0] bw_n;
  logic [DATA_W-1:0] dqi, dqo;
  logic [REG_AW-1:0] ra;
  logic [REG_DW-1:0] rwd, rrdata;
  int                miscompares, total_checks;
  always #2.5 clk = ~clk;
  srbc_core dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_clk_enable_n(cke_n), .i_burst_step_enable(step),
    .i_addr(addr), .i_write_n(wr_n), .i_byte_write_n(bw_n), .i_chip_en1_n(!sel), .i_chip_en2(sel),
    .i_chip_en3_n(!sel), .i_out_en_n(1'b0), .i_sleep_request(slp), .i_burst_order_select_n(ord_n),
    .i_dq(dqi), .o_dq(dqo), .o_dq_oe(oe), .o_sleep_active(act), .i_reg_addr(ra),
    .i_reg_wdata(rwd), .i_reg_wr(rwr), .i_reg_rd(rrd), .o_reg_rdata(rrdata)
  );
  srbc_ctl_model ctl (
    .i_core_clk(clk), .o_cke_n(cke_n), .o_step(step), .o_addr(addr), .o_wr_n(wr_n),
    .o_bw_n(bw_n), .o_sel(sel), .o_slp(slp), .o_ord_n(ord_n), .o_dq(dqi)
  );
  function automatic logic [DATA_W-1:0] pat(input logic [1:0] lo, input logic [3:0] k);
    pat = {k, 32'h5a5a_0000} ^ DATA_W'(lo);
  endfunction
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic reg_write(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    ra <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask
  task automatic reg_read(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    #1 d = rrdata;
  endtask
  task automatic wait_act(input logic v, output int n);
    n = 0;
    while (act !== v && n < 12)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (act !== v)
    begin
      miscompares++;
      finish_test();
    end
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [REG_DW-1:0] d;
    reg_read(REG_RECOVERY_OFS, d);
    check(d, REG_DW'(RECOVERY_RST), "recovery reset");
    reg_write(REG_RECOVERY_OFS, 32'h0000_0004);
    reg_read(REG_RECOVERY_OFS, d);
    check(d, 32'h0000_0004, "recovery rw");
    reg_read(8'h08, d);
    check(d, '0, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_write_words();
    for (int i = 0; i < 4; i++)
      ctl.cyc(1'b0, 1'b0, 4'h0, 1'b1, UP | ADDR_W'(i), i > 0, pat(2'(i - 1), 4'h1));
    ctl.cyc(1'b0, 1'b1, 4'hf, 1'b0, UP, 1'b1, pat(2'd3, 4'h1));
    #1 check(oe, 1'b0, "write oe");
    $display("test write_words done");
  endtask
  // keep marks words expected to hold the first pattern
  task automatic burst_read(input logic ord, input logic [1:0] base, input logic [3:0] k, input logic [3:0] keep);
    logic [1:0]        lo;
    logic [ADDR_W-1:0] a;
    a = UP | ADDR_W'(base);
    ctl.mode(1'b0, ord, 1'b0);
    for (int b = 0; b < 5; b++)
    begin
      // continue cycles carry a wrong address so only the counter can be right
      ctl.cyc(b > 0, 1'b1, 4'hf, 1'b1, b > 0 ? ~a : a, 1'b0, '0);
      lo = ord ? base ^ 2'(b) : base + 2'(b);
      #1 check(dqo, pat(lo, keep[lo] ? 4'h1 : k), "beat");
      check(oe, 1'b1, "read oe");
      if (b == 2)
      begin
        ctl.mode(1'b1, ord, 1'b0);
        @(posedge clk);
        ctl.mode(1'b0, ord, 1'b0);
        #1 check(dqo, pat(lo, keep[lo] ? 4'h1 : k), "hold");
      end
    end
    ctl.cyc(1'b0, 1'b1, 4'hf, 1'b0, a, 1'b0, '0);
    $display("test burst_read done");
  endtask
  task automatic t_abort();
    ctl.cyc(1'b0, 1'b0, 4'h0, 1'b1, UP, 1'b0, '0);
    ctl.cyc(1'b1, 1'b1, 4'h0, 1'b0, ~UP, 1'b1, pat(2'd0, 4'h2));
    ctl.cyc(1'b1, 1'b0, 4'hf, 1'b0, ~UP, 1'b1, pat(2'd1, 4'h2));
    ctl.cyc(1'b1, 1'b0, 4'h0, 1'b0, ~UP, 1'b1, pat(2'd2, 4'h2));
    ctl.cyc(1'b0, 1'b1, 4'hf, 1'b0, UP, 1'b1, pat(2'd3, 4'h2));
    burst_read(1'b0, 2'd0, 4'h2, 4'b0100);
  endtask
  task automatic t_sleep();
    logic [REG_DW-1:0] st;
    int                n;
    ctl.mode(1'b1, 1'b0, 1'b1);
    wait_act(1'b1, n);
    // three stages plus the agreeing edge, then the entry delay
    check(DATA_W'(n), DATA_W'(4 + SLEEP_ENTRY_CYC), "sleep entry");
    ctl.mode(1'b0, 1'b0, 1'b1);
    check(oe, 1'b0, "asleep oe");
    ctl.cyc(1'b0, 1'b0, 4'h0, 1'b1, UP, 1'b0, '0);
    ctl.cyc(1'b0, 1'b1, 4'hf, 1'b0, UP, 1'b1, pat(2'd0, 4'h3));
    reg_read(REG_STATUS_OFS, st);
    check(st[ST_SLP_LSB +: 2], SLP_ASLEEP, "status asleep");
    ctl.mode(1'b0, 1'b0, 1'b0);
    wait_act(1'b0, n);
    n = 0;
    do
    begin
      ctl.cyc(1'b0, 1'b1, 4'hf, 1'b1, UP, 1'b0, '0);
      #1 n++;
    end while (oe !== 1'b1 && n < 30);
    check(n >= 3 && n < 30, 1'b1, "recovery");
    if (n == 30)
      finish_test();
    check(dqo, pat(2'd0, 4'h2), "kept word");
    $display("test sleep done");
  endtask
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {ra, rwd, rwr, rrd} = '0;
    miscompares = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_write_words();
    burst_read(1'b0, 2'd1, 4'h1, 4'h0);
    burst_read(1'b1, 2'd3, 4'h1, 4'h0);
    t_abort();
    t_sleep();
    finish_test();
  end
endmodule
`default_nettype wire
